// >>> hdl/dro_regfile.sv
`timescale 1ns/1ps
// Summary of operation
// - general regs undefined; stack pointer from vector table
// - status word mask ones; rc, modulo cleared
// - vector base and dsp condition cleared
// - program counter loaded from vector table
// - operands 32 bits; byte/word loads sign-extended
// - misaligned word/longword access raises address error
// - arithmetic immediates sign-extend, logical zero-extend
// - fixed point between bits 31 and 30
// - integer point between bits 16 and 15
// - arithmetic shift 7 bits, valid -32..+32
// - logical shift 6 bits, valid -16..+16
// - accumulator supplies guard; others sign-extend
// - accumulator keeps guard; others discard it
// - integer ignores/clears low half; guard unchanged
// - logical uses upper word; clears rest
// - x/y transfers move upper word on 16 bits
// - x/y loads target own operand regs
// - x/y stores only from accumulator upper word
// - single transfers reach all dsp registers
// - guard registers addressable, 8-bit data length
// - guard store sign-extends; accumulator drops guard
// - accumulators 40 bits; others 32 bits
// - word load to accumulator sign-extends guard
module dro_regfile (
	input  wire logic                  mclk_in,
	input  wire logic                  rst_n_in,
	// reset vectors
	input  wire logic [31:0]           vec_pc_in,
	input  wire logic [31:0]           vec_sp_in,
	// memory side for alignment and extension
	input  wire logic                  mem_vld_in,
	input  wire dro_pkg::dro_size_t    mem_size_in,
	input  wire logic [31:0]           mem_addr_in,
	input  wire logic [31:0]           mem_rdata_in,
	input  wire logic                  imm_vld_in,
	input  wire dro_pkg::dro_imm_t     imm_class_in,
	input  wire logic [7:0]            imm_in,
	// dsp processing
	input  wire logic                  dsp_wr_in,
	input  wire dro_pkg::dro_fmt_t     dsp_fmt_in,
	input  wire dro_pkg::dro_reg_t     dsp_src_in,
	input  wire dro_pkg::dro_reg_t     dsp_dst_in,
	input  wire logic [39:0]           dsp_result_in,
	input  wire logic [6:0]            shift_amt_in,
	input  wire logic                  shift_logical_in,
	// x and y memory transfers
	input  wire logic                  x_ld_in,
	input  wire logic                  y_ld_in,
	input  wire logic                  xy_dst_one_in,
	input  wire logic [15:0]           x_bus_in,
	input  wire logic [15:0]           y_bus_in,
	input  wire logic                  xy_st_in,
	input  wire logic                  xy_st_one_in,
	// single transfers over the core data bus
	input  wire logic                  cdb_ld_in,
	input  wire logic                  cdb_long_in,
	input  wire dro_pkg::dro_reg_t     cdb_reg_in,
	input  wire logic [31:0]           cdb_wdata_in,
	// outputs
	output logic [31:0]                program_counter_out,
	output logic [31:0]                stack_pointer_reg_out,
	output logic [31:0]                status_word_out,
	output logic [31:0]                vector_base_reg_out,
	output logic [31:0]                dsp_cond_out,
	output logic [39:0]                dsp_src_out,
	output logic [15:0]                xy_store_out,
	output logic                       xy_store_vld_out,
	output logic [31:0]                cdb_rdata_out,
	output logic                       shift_valid_out,
	output logic                       reset_done_out,
	output logic [31:0]                load_word_out,
	output logic                       load_vld_out,
	output logic                       addr_error_out,
	output logic [31:0]                imm_word_out,
	output logic                       sp_misaligned_out
);
	// ==========================================
	// storage: 40-bit accumulators, 32-bit operand regs
	logic [31:0] acc_body [2];
	logic [7:0]  acc_guard [2];
	logic [31:0] dreg [6];
	dro_pkg::dro_state_t state;

	// sign-extend a 32-bit value to the 40-bit alu width
	function automatic logic [39:0] sext40(input logic [31:0] v);
		sext40 = {{8{v[31]}}, v};
	endfunction

	// upper half into a 32-bit register, lower half cleared
	function automatic logic [31:0] hi_only(input logic [15:0] v);
		hi_only = {v, 16'h0000};
	endfunction

	function automatic logic is_acc(input dro_pkg::dro_reg_t r);
		is_acc = (r == dro_pkg::DRO_A0) || (r == dro_pkg::DRO_A1);
	endfunction

	// operand register index for x0..m1
	function automatic logic [2:0] dix(input dro_pkg::dro_reg_t r);
		dix = 3'(r - dro_pkg::DRO_X0);
	endfunction

	// ==========================================
	// reset sequencer: vector entries latched after release
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= dro_pkg::DRO_ST_RESET;
		end else begin
			unique case (state)
				dro_pkg::DRO_ST_RESET: state <= dro_pkg::DRO_ST_FETCH;
				dro_pkg::DRO_ST_FETCH: state <= dro_pkg::DRO_ST_RUN;
				dro_pkg::DRO_ST_RUN:   state <= dro_pkg::DRO_ST_RUN;
				default:               state <= dro_pkg::DRO_ST_RESET;
			endcase
		end
	end

	// vector values are ports, so they are caught by the clock, not the reset
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			program_counter_out   <= 32'h0000_0000;
			stack_pointer_reg_out <= 32'h0000_0000;
			reset_done_out        <= 1'b0;
		end else if (state == dro_pkg::DRO_ST_FETCH) begin
			program_counter_out   <= vec_pc_in;
			stack_pointer_reg_out <= vec_sp_in;
			reset_done_out        <= 1'b1;
		end
	end

	// ==========================================
	// control registers; undefined fields simply come up zero here
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_word_out     <= {24'h00_0000, dro_pkg::IMASK_RESET, 4'h0};
			vector_base_reg_out <= dro_pkg::VBR_RESET;
			dsp_cond_out        <= dro_pkg::DCR_RESET;
		end
	end

	// ==========================================
	// shift amount validity
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			shift_valid_out <= 1'b0;
		end else if (shift_logical_in) begin
			shift_valid_out <= $signed(shift_amt_in[5:0]) >= dro_pkg::LSH_MIN &&
			                   $signed(shift_amt_in[5:0]) <= dro_pkg::LSH_MAX;
		end else begin
			shift_valid_out <= $signed(shift_amt_in) >= dro_pkg::ASH_MIN &&
			                   $signed(shift_amt_in) <= dro_pkg::ASH_MAX;
		end
	end

	// ==========================================
	// source operand formatting, binary point fixed by register bit
	logic [39:0] src_raw;
	always_comb begin
		if (is_acc(dsp_src_in))
			src_raw = {acc_guard[dsp_src_in[0]], acc_body[dsp_src_in[0]]};
		else if (dsp_src_in <= dro_pkg::DRO_M1)
			src_raw = sext40(dreg[dix(dsp_src_in)]);
		else
			src_raw = 40'h00_0000_0000;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dsp_src_out <= 40'h00_0000_0000;
		end else begin
			unique case (dsp_fmt_in)
				dro_pkg::DRO_FIX: dsp_src_out <= src_raw;
				dro_pkg::DRO_INT: dsp_src_out <= {src_raw[39:16], 16'h0000};
				dro_pkg::DRO_LOG: dsp_src_out <= {8'h00, src_raw[31:16], 16'h0000};
				default:          dsp_src_out <= src_raw;
			endcase
		end
	end

	// ==========================================
	// accumulator writes: processing, x/y has none, single transfer
	always_ff @(posedge mclk_in) begin
		for (int i = 0; i < 2; i++) begin
			if (dsp_wr_in && is_acc(dsp_dst_in) && dsp_dst_in[0] == 1'(i)) begin
				unique case (dsp_fmt_in)
					dro_pkg::DRO_FIX: begin
						acc_guard[i] <= dsp_result_in[39:32];
						acc_body[i]  <= dsp_result_in[31:0];
					end
					dro_pkg::DRO_INT: begin
						acc_guard[i] <= dsp_result_in[39:32];
						acc_body[i]  <= {dsp_result_in[31:16], 16'h0000};
					end
					default: begin
						acc_guard[i] <= 8'h00;
						acc_body[i]  <= hi_only(dsp_result_in[31:16]);
					end
				endcase
			end else if (cdb_ld_in && is_acc(cdb_reg_in) && cdb_reg_in[0] == 1'(i)) begin
				if (cdb_long_in) begin
					acc_body[i]  <= cdb_wdata_in;
					acc_guard[i] <= {8{cdb_wdata_in[31]}};
				end else begin
					acc_body[i]  <= hi_only(cdb_wdata_in[15:0]);
					acc_guard[i] <= {8{cdb_wdata_in[15]}};
				end
			end else if (cdb_ld_in && cdb_reg_in == (i == 0 ? dro_pkg::DRO_A0G : dro_pkg::DRO_A1G)) begin
				acc_guard[i] <= cdb_wdata_in[7:0];
			end
		end
	end

	// operand registers: guard bits of a result are discarded
	always_ff @(posedge mclk_in) begin
		for (int i = 0; i < 6; i++) begin
			if (dsp_wr_in && !is_acc(dsp_dst_in) && dsp_dst_in <= dro_pkg::DRO_M1 &&
			    dix(dsp_dst_in) == 3'(i)) begin
				if (dsp_fmt_in == dro_pkg::DRO_FIX)
					dreg[i] <= dsp_result_in[31:0];
				else
					dreg[i] <= hi_only(dsp_result_in[31:16]);
			end else if (x_ld_in && i == (xy_dst_one_in ? 1 : 0)) begin
				dreg[i] <= hi_only(x_bus_in);
			end else if (y_ld_in && i == (xy_dst_one_in ? 3 : 2)) begin
				dreg[i] <= hi_only(y_bus_in);
			end else if (cdb_ld_in && !is_acc(cdb_reg_in) && cdb_reg_in <= dro_pkg::DRO_M1 &&
			             dix(cdb_reg_in) == 3'(i)) begin
				dreg[i] <= cdb_long_in ? cdb_wdata_in : hi_only(cdb_wdata_in[15:0]);
			end
		end
	end

	// ==========================================
	// x/y store: only the upper word of an accumulator
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			xy_store_out     <= 16'h0000;
			xy_store_vld_out <= 1'b0;
		end else begin
			xy_store_vld_out <= xy_st_in;
			if (xy_st_in)
				xy_store_out <= acc_body[xy_st_one_in][31:16];
		end
	end

	// single store: word mode upper half, guard sign-extended
	logic [31:0] next_cdb;
	always_comb begin
		next_cdb = 32'h0000_0000;
		if (cdb_reg_in == dro_pkg::DRO_A0G || cdb_reg_in == dro_pkg::DRO_A1G)
			next_cdb = {{24{acc_guard[cdb_reg_in[0]][7]}}, acc_guard[cdb_reg_in[0]]};
		else if (is_acc(cdb_reg_in))
			next_cdb = cdb_long_in ? acc_body[cdb_reg_in[0]] :
			           {{16{acc_body[cdb_reg_in[0]][31]}}, acc_body[cdb_reg_in[0]][31:16]};
		else if (cdb_reg_in <= dro_pkg::DRO_M1)
			next_cdb = cdb_long_in ? dreg[dix(cdb_reg_in)] :
			           {{16{dreg[dix(cdb_reg_in)][31]}}, dreg[dix(cdb_reg_in)][31:16]};
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) cdb_rdata_out <= 32'h0000_0000;
		else cdb_rdata_out <= next_cdb;
	end

	// ==========================================
	// memory and immediate formatting
	dro_mem_format dro_mem_format_inst (
		.mclk_in             (mclk_in),
		.rst_n_in            (rst_n_in),
		.mem_vld_in          (mem_vld_in),
		.mem_size_in         (mem_size_in),
		.mem_addr_in         (mem_addr_in),
		.mem_rdata_in        (mem_rdata_in),
		.imm_vld_in          (imm_vld_in),
		.imm_class_in        (imm_class_in),
		.imm_in              (imm_in),
		.stack_top_pointer_in(stack_pointer_reg_out),
		.load_word_out       (load_word_out),
		.load_vld_out        (load_vld_out),
		.addr_error_out      (addr_error_out),
		.imm_word_out        (imm_word_out),
		.sp_misaligned_out   (sp_misaligned_out)
	);

	// ==========================================
	sequence s_fetch;
		state == dro_pkg::DRO_ST_FETCH;
	endsequence
	a_pc_vector: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		s_fetch ##1 1'b1 |-> program_counter_out == $past(vec_pc_in)) else $error("pc not from vector");
	a_sp_vector: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		s_fetch |=> stack_pointer_reg_out == $past(vec_sp_in)) else $error("sp not from vector");
	a_status_mask: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		status_word_out[7:4] == dro_pkg::IMASK_RESET && status_word_out[27:16] == 12'h0)
		else $error("status word reset wrong");
	a_ctrl_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		vector_base_reg_out == 32'h0 && dsp_cond_out == 32'h0) else $error("control not cleared");
	a_logic_src: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		dsp_fmt_in == dro_pkg::DRO_LOG |=> dsp_src_out[15:0] == 16'h0 && dsp_src_out[39:32] == 8'h0)
		else $error("logical source not masked");
	a_int_src: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		dsp_fmt_in == dro_pkg::DRO_INT |=> dsp_src_out[15:0] == 16'h0) else $error("integer low half kept");
	a_xy_store: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		xy_st_in && !xy_st_one_in |=> xy_store_vld_out && xy_store_out == $past(acc_body[0][31:16]))
		else $error("xy store not acc upper word");
	a_lsh_range: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		shift_logical_in && shift_amt_in[5:0] == 6'h11 |=> !shift_valid_out) else $error("shift 17 accepted");
	a_ash_range: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!shift_logical_in && shift_amt_in == 7'h20 |=> shift_valid_out) else $error("shift 32 refused");
endmodule

// >>> shared/dro_pkg.sv
package dro_pkg;
	// ==========================================
	// widths and field positions
	localparam int WORD_W   = 32;
	localparam int HALF_W   = 16;
	localparam int GUARD_W  = 8;
	localparam int ACC_W    = 40;
	localparam int HI_LSB   = 16;
	localparam int SIGN_BIT = 31;
	localparam int GRD_LSB  = 32;
	// fixed-point binary point sits below bit 31, integer point below bit 16
	localparam int FIX_POINT = 31;
	localparam int INT_POINT = 16;

	// ==========================================
	// reset values
	localparam logic [31:0] VBR_RESET   = 32'h0000_0000;
	localparam logic [31:0] DCR_RESET   = 32'h0000_0000;
	localparam logic [3:0]  IMASK_RESET = 4'hf;
	localparam int          IMASK_LSB   = 4;
	localparam int          MODX_BIT    = 10;
	localparam int          MODY_BIT    = 11;
	localparam int          RC_LSB      = 16;
	localparam int          RC_W        = 12;
	localparam int          SW_USED_LSB = 0;
	localparam logic [31:0] SW_UNDEF_MASK = 32'h0000_030f;

	// ==========================================
	// shift amount bounds
	localparam logic signed [6:0] ASH_MIN = -7'sd32;
	localparam logic signed [6:0] ASH_MAX = 7'sd32;
	localparam logic signed [5:0] LSH_MIN = -6'sd16;
	localparam logic signed [5:0] LSH_MAX = 6'sd16;

	// ==========================================
	// dsp register select codes
	typedef enum logic [3:0] {
		DRO_A0 = 4'h0, DRO_A1 = 4'h1, DRO_X0 = 4'h2, DRO_X1 = 4'h3,
		DRO_Y0 = 4'h4, DRO_Y1 = 4'h5, DRO_M0 = 4'h6, DRO_M1 = 4'h7,
		DRO_A0G = 4'h8, DRO_A1G = 4'h9
	} dro_reg_t;

	// processing format
	typedef enum logic [1:0] {
		DRO_FIX = 2'h0, DRO_INT = 2'h1, DRO_LOG = 2'h3
	} dro_fmt_t;

	// immediate operation class
	typedef enum logic [1:0] {
		DRO_IMM_SEXT = 2'h0, DRO_IMM_ZEXT = 2'h1
	} dro_imm_t;

	// memory access size
	typedef enum logic [1:0] {
		DRO_SZ_B = 2'h0, DRO_SZ_W = 2'h1, DRO_SZ_L = 2'h2
	} dro_size_t;

	// reset sequencer
	typedef enum logic [1:0] {
		DRO_ST_RESET = 2'b00, DRO_ST_FETCH = 2'b01, DRO_ST_RUN = 2'b11
	} dro_state_t;
endpackage

// >>> hdl/dro_mem_format.sv
`timescale 1ns/1ps
// memory load extension, immediate extension and alignment checks
module dro_mem_format (
	input  wire logic                  mclk_in,
	input  wire logic                  rst_n_in,
	input  wire logic                  mem_vld_in,
	input  wire dro_pkg::dro_size_t    mem_size_in,
	input  wire logic [31:0]           mem_addr_in,
	input  wire logic [31:0]           mem_rdata_in,
	input  wire logic                  imm_vld_in,
	input  wire dro_pkg::dro_imm_t     imm_class_in,
	input  wire logic [7:0]            imm_in,
	input  wire logic [31:0]           stack_top_pointer_in,
	output logic [31:0]                load_word_out,
	output logic                       load_vld_out,
	output logic                       addr_error_out,
	output logic [31:0]                imm_word_out,
	output logic                       sp_misaligned_out
);
	logic misaligned;

	// word needs even address, longword a multiple of four
	always_comb begin
		unique case (mem_size_in)
			dro_pkg::DRO_SZ_W: misaligned = mem_addr_in[0];
			dro_pkg::DRO_SZ_L: misaligned = |mem_addr_in[1:0];
			default:           misaligned = 1'b0;
		endcase
	end

	// ==========================================
	// registered load path
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			load_word_out  <= 32'h0000_0000;
			load_vld_out   <= 1'b0;
			addr_error_out <= 1'b0;
		end else begin
			load_vld_out   <= mem_vld_in && !misaligned;
			addr_error_out <= mem_vld_in && misaligned;
			unique case (mem_size_in)
				dro_pkg::DRO_SZ_B: load_word_out <= {{24{mem_rdata_in[7]}}, mem_rdata_in[7:0]};
				dro_pkg::DRO_SZ_W: load_word_out <= {{16{mem_rdata_in[15]}}, mem_rdata_in[15:0]};
				default:           load_word_out <= mem_rdata_in;
			endcase
		end
	end

	// ==========================================
	// immediate path; zero extension makes an and clear the upper 24 bits
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			imm_word_out <= 32'h0000_0000;
		end else if (imm_vld_in) begin
			if (imm_class_in == dro_pkg::DRO_IMM_SEXT)
				imm_word_out <= {{24{imm_in[7]}}, imm_in};
			else
				imm_word_out <= {24'h00_0000, imm_in};
		end
	end

	// stack top kept on a longword boundary by software; flag otherwise
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) sp_misaligned_out <= 1'b0;
		else sp_misaligned_out <= |stack_top_pointer_in[1:0];
	end

	a_word_align: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		mem_vld_in && mem_size_in == dro_pkg::DRO_SZ_W && mem_addr_in[0]
		|=> addr_error_out && !load_vld_out) else $error("misaligned word not flagged");
	a_byte_sext: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		mem_vld_in && mem_size_in == dro_pkg::DRO_SZ_B
		|=> load_word_out == {{24{$past(mem_rdata_in[7])}}, $past(mem_rdata_in[7:0])})
		else $error("byte load not sign extended");
	a_imm_zext: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		imm_vld_in && imm_class_in == dro_pkg::DRO_IMM_ZEXT |=> imm_word_out[31:8] == 24'h0)
		else $error("logical immediate not zero extended");
endmodule

// >>> testbench/dro_mem_model.sv
`timescale 1ns/1ps
// ==========================================
// far side: vector table entries plus x and y word memories
module dro_mem_model #(
	parameter logic [31:0] VEC_PC = 32'h0000_0400,
	parameter logic [31:0] VEC_SP = 32'h0000_1000
) (
	input  wire logic        mclk_in,
	input  wire logic [3:0]  x_addr_in,
	input  wire logic [3:0]  y_addr_in,
	input  wire logic        st_vld_in,
	input  wire logic [15:0] st_data_in,
	output logic [31:0]      vec_pc_out,
	output logic [31:0]      vec_sp_out,
	output logic [15:0]      x_data_out,
	output logic [15:0]      y_data_out
);
	logic [15:0] x_mem [16];
	logic [15:0] y_mem [16];
	// table entries; stack entry forced to a multiple of four
	assign vec_pc_out = VEC_PC;
	assign vec_sp_out = {VEC_SP[31:2], 2'b00};
	// 16-bit buses carry only one word each way
	assign x_data_out = x_mem[x_addr_in];
	assign y_data_out = y_mem[y_addr_in];
	// known preload so loads have something to fetch
	initial begin
		for (int i = 0; i < 16; i++) begin
			x_mem[i] = 16'h1234 + 16'(i);
			y_mem[i] = 16'h8765 + 16'(i);
		end
	end
	// stores land in x memory at the current x address
	always @(posedge mclk_in) begin
		if (st_vld_in) begin
			x_mem[x_addr_in] <= st_data_in;
		end
	end
endmodule

// >>> testbench/tb_dro_regfile.sv
`timescale 1ns/1ps
module tb_dro_regfile;
	localparam logic [31:0] VPC = 32'h0000_0400;
	localparam logic [31:0] VSP = 32'h0000_1000;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic mem_vld_in, imm_vld_in, dsp_wr_in, shift_logical_in, x_ld_in, y_ld_in;
	logic xy_dst_one_in, xy_st_in, xy_st_one_in, cdb_ld_in, cdb_long_in;
	logic [31:0] mem_addr_in, mem_rdata_in, cdb_wdata_in, vec_pc_in, vec_sp_in;
	logic [39:0] dsp_result_in;
	logic [15:0] x_bus_in, y_bus_in;
	logic [7:0] imm_in;
	logic [6:0] shift_amt_in;
	logic [3:0] x_addr, y_addr;
	dro_pkg::dro_size_t mem_size_in;
	dro_pkg::dro_imm_t imm_class_in;
	dro_pkg::dro_fmt_t dsp_fmt_in;
	dro_pkg::dro_reg_t dsp_src_in, dsp_dst_in, cdb_reg_in;
	logic [31:0] program_counter_out, stack_pointer_reg_out, status_word_out;
	logic [31:0] vector_base_reg_out, dsp_cond_out, cdb_rdata_out, load_word_out, imm_word_out;
	logic [39:0] dsp_src_out;
	logic [15:0] xy_store_out;
	logic xy_store_vld_out, shift_valid_out, reset_done_out, load_vld_out;
	logic addr_error_out, sp_misaligned_out;
	int failures = 0;
	int compares = 0;
	int cycles = 0;

	// ==========================================
	// clock, design and far-side model
	always #2.5 mclk_in = ~mclk_in;
	dro_regfile dro_regfile_inst (.mclk_in, .rst_n_in, .vec_pc_in, .vec_sp_in, .mem_vld_in,
		.mem_size_in, .mem_addr_in, .mem_rdata_in, .imm_vld_in, .imm_class_in, .imm_in,
		.dsp_wr_in, .dsp_fmt_in, .dsp_src_in, .dsp_dst_in, .dsp_result_in, .shift_amt_in,
		.shift_logical_in, .x_ld_in, .y_ld_in, .xy_dst_one_in, .x_bus_in, .y_bus_in,
		.xy_st_in, .xy_st_one_in, .cdb_ld_in, .cdb_long_in, .cdb_reg_in, .cdb_wdata_in,
		.program_counter_out, .stack_pointer_reg_out, .status_word_out, .vector_base_reg_out,
		.dsp_cond_out, .dsp_src_out, .xy_store_out, .xy_store_vld_out, .cdb_rdata_out,
		.shift_valid_out, .reset_done_out, .load_word_out, .load_vld_out, .addr_error_out,
		.imm_word_out, .sp_misaligned_out);
	dro_mem_model #(.VEC_PC(VPC), .VEC_SP(VSP)) dro_mem_model_inst (.mclk_in,
		.x_addr_in(x_addr), .y_addr_in(y_addr), .st_vld_in(xy_store_vld_out),
		.st_data_in(xy_store_out), .vec_pc_out(vec_pc_in), .vec_sp_out(vec_sp_in),
		.x_data_out(x_bus_in), .y_data_out(y_bus_in));

	// ==========================================
	// shared helpers
	task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// cdb single transfers; data is registered, so one cycle per access
	task automatic cdb_wr(input dro_pkg::dro_reg_t r, input logic lng, input logic [31:0] d);
		cdb_reg_in = r;
		cdb_long_in = lng;
		cdb_wdata_in = d;
		cdb_ld_in = 1'b1;
		@(negedge mclk_in);
		cdb_ld_in = 1'b0;
	endtask
	task automatic cdb_rd(input dro_pkg::dro_reg_t r, input logic lng, input logic [31:0] e);
		cdb_reg_in = r;
		cdb_long_in = lng;
		@(negedge mclk_in);
		check("cdb_rdata", {8'h00, cdb_rdata_out}, {8'h00, e});
	endtask
	task automatic mem_ld(input dro_pkg::dro_size_t s, input logic [31:0] a, d, e, input logic err);
		mem_size_in = s;
		mem_addr_in = a;
		mem_rdata_in = d;
		mem_vld_in = 1'b1;
		@(negedge mclk_in);
		check("addr_error", 40'(addr_error_out), 40'(err));
		check("load_vld", 40'(load_vld_out), 40'(!err));
		if (!err) check("load_word", 40'(load_word_out), 40'(e));
	endtask
	task automatic dsp_wr(input dro_pkg::dro_fmt_t f, dro_pkg::dro_reg_t r, logic [39:0] d);
		dsp_fmt_in = f;
		dsp_dst_in = r;
		dsp_result_in = d;
		dsp_wr_in = 1'b1;
		@(negedge mclk_in);
		dsp_wr_in = 1'b0;
	endtask

	// ==========================================
	// hang guard: the whole sequence needs well under 200 cycles
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			close_out();
		end
	end

	// ==========================================
	// main sequence
	initial begin
		{mem_vld_in, imm_vld_in, dsp_wr_in, shift_logical_in, x_ld_in, y_ld_in} = '0;
		{xy_dst_one_in, xy_st_in, xy_st_one_in, cdb_ld_in, cdb_long_in} = '0;
		{mem_addr_in, mem_rdata_in, cdb_wdata_in, dsp_result_in, imm_in, shift_amt_in} = '0;
		{x_addr, y_addr} = '0;
		mem_size_in = dro_pkg::DRO_SZ_B;
		imm_class_in = dro_pkg::DRO_IMM_SEXT;
		dsp_fmt_in = dro_pkg::DRO_FIX;
		dsp_src_in = dro_pkg::DRO_A0;
		dsp_dst_in = dro_pkg::DRO_A0;
		cdb_reg_in = dro_pkg::DRO_A0;
		repeat (16) @(negedge mclk_in);
		check("sw_in_reset", 40'(status_word_out), 40'h00_0000_00f0);
		check("done_in_reset", 40'(reset_done_out), 40'h0);
		rst_n_in = 1'b1;
		repeat (2) @(negedge mclk_in);
		check("reset_done", 40'(reset_done_out), 40'h1);
		check("pc", 40'(program_counter_out), 40'(VPC));
		check("sp", 40'(stack_pointer_reg_out), 40'(VSP));
		check("sp_align", 40'(sp_misaligned_out), 40'h0);
		check("sw", 40'(status_word_out), 40'h00_0000_00f0);
		check("vbr", 40'(vector_base_reg_out), 40'h0);
		check("dsr", 40'(dsp_cond_out), 40'h0);
		// extension and alignment, misaligned cases refused
		mem_ld(dro_pkg::DRO_SZ_B, 32'h0000_0003, 32'h0000_0080, 32'hffff_ff80, 1'b0);
		mem_ld(dro_pkg::DRO_SZ_W, 32'h0000_0002, 32'h0000_8001, 32'hffff_8001, 1'b0);
		mem_ld(dro_pkg::DRO_SZ_W, 32'h0000_0001, 32'h0000_8001, 32'h0, 1'b1);
		mem_ld(dro_pkg::DRO_SZ_L, 32'h0000_0004, 32'h89ab_cdef, 32'h89ab_cdef, 1'b0);
		mem_ld(dro_pkg::DRO_SZ_L, 32'h0000_0002, 32'h89ab_cdef, 32'h0, 1'b1);
		// strobe held across the run of loads, dropped once at the end
		mem_vld_in = 1'b0;
		// immediates: same byte, both classes
		imm_in = 8'h80;
		imm_vld_in = 1'b1;
		@(negedge mclk_in);
		check("imm_sext", 40'(imm_word_out), 40'hffff_ff80);
		imm_class_in = dro_pkg::DRO_IMM_ZEXT;
		@(negedge mclk_in);
		imm_vld_in = 1'b0;
		check("imm_zext", 40'(imm_word_out), 40'h80);
		// shift bounds: even entries valid, odd just outside
		for (int i = 0; i < 8; i++) begin
			{shift_logical_in, shift_amt_in} = 8'(64'h2021_605f_9091_f0ef >> (56 - 8 * i));
			@(negedge mclk_in);
			check("shift_valid", 40'(shift_valid_out), 40'(i % 2 == 0));
		end
		// x and y loads from the model's memories
		x_ld_in = 1'b1;
		@(negedge mclk_in);
		x_ld_in = 1'b0;
		y_ld_in = 1'b1;
		xy_dst_one_in = 1'b1;
		@(negedge mclk_in);
		y_ld_in = 1'b0;
		cdb_rd(dro_pkg::DRO_X0, 1'b1, 32'h1234_0000);
		cdb_rd(dro_pkg::DRO_Y1, 1'b0, 32'hffff_8765);
		// fixed-point writes: accumulator keeps guard, others drop it
		dsp_wr(dro_pkg::DRO_FIX, dro_pkg::DRO_A0, 40'h7f_8000_0001);
		@(negedge mclk_in);
		dsp_wr(dro_pkg::DRO_FIX, dro_pkg::DRO_X1, 40'h7f_8000_0001);
		dsp_src_in = dro_pkg::DRO_A0;
		@(negedge mclk_in);
		check("src_a0", dsp_src_out, 40'h7f_8000_0001);
		dsp_src_in = dro_pkg::DRO_X1;
		@(negedge mclk_in);
		check("src_x1", dsp_src_out, 40'hff_8000_0001);
		cdb_rd(dro_pkg::DRO_A0G, 1'b0, 32'h0000_007f);
		// integer and logical writes clear low words; logical also clears guard
		dsp_wr(dro_pkg::DRO_INT, dro_pkg::DRO_M0, 40'h00_1234_5678);
		cdb_rd(dro_pkg::DRO_M0, 1'b1, 32'h1234_0000);
		dsp_wr(dro_pkg::DRO_LOG, dro_pkg::DRO_A1, 40'h55_abcd_1234);
		cdb_rd(dro_pkg::DRO_A1, 1'b1, 32'habcd_0000);
		cdb_rd(dro_pkg::DRO_A1G, 1'b1, 32'h0000_0000);
		// store upper word of accumulator one into x memory
		x_addr = 4'h5;
		xy_st_one_in = 1'b1;
		xy_st_in = 1'b1;
		@(negedge mclk_in);
		xy_st_in = 1'b0;
		check("st_vld", 40'(xy_store_vld_out), 40'h1);
		check("st_data", 40'(xy_store_out), 40'habcd);
		@(negedge mclk_in);
		check("xmem", 40'(x_bus_in), 40'habcd);
		// store from accumulator zero as well, upper word only
		xy_st_one_in = 1'b0;
		xy_st_in = 1'b1;
		@(negedge mclk_in);
		xy_st_in = 1'b0;
		check("st_a0", 40'(xy_store_out), 40'h8000);
		// single loads: accumulator word, guard alone, long
		cdb_wr(dro_pkg::DRO_A0, 1'b0, 32'h0000_9abc);
		cdb_rd(dro_pkg::DRO_A0G, 1'b0, 32'hffff_ffff);
		cdb_wr(dro_pkg::DRO_A0G, 1'b0, 32'h0000_0012);
		cdb_rd(dro_pkg::DRO_A0, 1'b1, 32'h9abc_0000);
		cdb_rd(dro_pkg::DRO_A0G, 1'b1, 32'h0000_0012);
		cdb_wr(dro_pkg::DRO_X0, 1'b1, 32'hdead_beef);
		cdb_rd(dro_pkg::DRO_X0, 1'b1, 32'hdead_beef);
		close_out();
	end
endmodule
